// [one_wire_debug_port_defines.vh]
`ifndef ONE_WIRE_DEBUG_PORT_DEFINES_VH
`define ONE_WIRE_DEBUG_PORT_DEFINES_VH

// Register byte offsets.
`define OFS_CTRL 8'h00
`define OFS_ASYNC_IFACE_CONTROL_A 8'h04
`define OFS_STATUS 8'h08
`define OFS_RXDATA 8'h0C
`define OFS_TXDATA 8'h10
`define OFS_CMD 8'h14
`define OFS_BAUD 8'h18

// Field positions.
`define CTRL_ENABLE 0
`define CTRL_PARITY_CHECK_DISABLE 1
`define CMD_STORE_GRANTED 0
`define CMD_EXPECT_SYNC 1
`define ST_RX_VALID 0
`define ST_TX_BUSY 1
`define ST_ERROR 2
`define ST_EXPECT_SYNC 3
`define ST_BUS_HELD 4
`define ST_SIG_LO 8
`define ST_SIG_HI 10

// Link clock selection codes and the resulting link clock in MHz.
`define CLKSEL_16 2'h1
`define CLKSEL_8 2'h2
`define CLKSEL_4 2'h3
`define CLKSEL_RESET 2'h3
`define FREQ_16 9'h010
`define FREQ_8 9'h008
`define FREQ_4 9'h004
`define PCLK_MHZ 9'h0C8

// Bit sampling.
`define SAMPLE_A 4'h7
`define SAMPLE_B 4'h8
`define SAMPLE_C 4'h9
`define SAMPLE_LAST 4'hF
`define BIT_START 4'h0
`define BIT_PARITY 4'h9
`define BIT_STOP1 4'hA
`define BIT_STOP2 4'hB

// Sync measurement spans eight bit times, 16 samples each.
`define SYNC_SCALE 20'h00080
`define SYNC_FALLS 3'h4
`define BAUD_DEFAULT 20'h00118
`define BAUD_MIN 20'h00080
`define BREAK_SAMPLES 8'hC0

// Acknowledge character value, a plain default.
`define ACK_CHAR 8'h40

// Error signature codes.
`define SIG_NONE 3'h0
`define SIG_START 3'h1
`define SIG_PARITY 3'h2
`define SIG_STOP 3'h3
`define SIG_SYNC 3'h4

`endif

// [one_wire_frame_tx.v]
`timescale 1ns/1ps
`include "one_wire_debug_port_defines.vh"
module one_wire_frame_tx (
	input wire pclk, // System clock.
	input wire presetn, // Asynchronous reset, active low.
	input wire sample_tick, // One pulse per sixteenth of a bit.
	input wire start, // Pulse: begin a frame.
	input wire [7:0] data, // Byte to send.
	output reg line_o, // Serial level to drive.
	output reg busy // Frame in progress.
);
	reg [11:0] frame;
	reg [3:0] samp;
	reg [3:0] bits;

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			frame <= 12'hFFF;
			samp <= 4'h0;
			bits <= 4'h0;
			line_o <= 1'b1;
			busy <= 1'b0;
		end else if (start && !busy) begin
			// Start, eight data, even parity, two stops.
			frame <= {2'b11, ^data, data, 1'b0};
			samp <= 4'h0;
			bits <= 4'h0;
			line_o <= 1'b0;
			busy <= 1'b1;
		end else if (busy && sample_tick) begin
			samp <= samp + 4'h1;
			if (samp == `SAMPLE_LAST) begin
				if (bits == `BIT_STOP2) begin
					busy <= 1'b0;
					line_o <= 1'b1;
				end else begin
					bits <= bits + 4'h1;
					frame <= {1'b1, frame[11:1]};
					line_o <= frame[1];
				end
			end
		end
	end
endmodule // one_wire_frame_tx

// [one_wire_debug_port.v]
// What this block does
// - Frame is start, eight data, parity, two stops.
// - Flag bad start, parity or stop bits.
// - Parity check skipped when disable bit set.
// - Idle frame equals twelve high bits.
// - Twelve low bits reset internal state.
// - Sync character sets the bit rate.
// - Sync precedes instructions and follows break.
// - Send acknowledge once store gains bus.
// - Stored rate used for receive and transmit.
// - No writable bit rate register.
// - Sixteen samples, vote on seven, eight, nine.
// - Fractional counting keeps timing error small.
// - Link clock starts 4 MHz, two-bit select.
// - Crossings between domains are synchronised.
// - Port controls pull, input and output enables.
// - Link runs in sleep; bus access held.
// - One shared wire, half duplex.
// - After error ignore data until break.
// - Break restores 4 MHz link clock.
//
// The placing of the registers and the APB register port were left to the implementer.
`timescale 1ns/1ps
`include "one_wire_debug_port_defines.vh"
module one_wire_debug_port (
	input wire pclk, // System clock, 200 MHz.
	input wire presetn, // Asynchronous reset, active low.
	input wire psel, // APB select.
	input wire penable, // APB enable.
	input wire pwrite, // APB direction, high for write.
	input wire [7:0] paddr, // APB byte address.
	input wire [31:0] pwdata, // APB write data.
	output reg [31:0] prdata, // APB read data.
	output reg pready, // APB ready.
	output reg pslverr, // APB error for unmapped address.
	input wire pin_in, // Level seen on the shared reset pin.
	output reg pin_out, // Level driven onto the pin.
	output reg pin_out_en, // High while the port drives the pin.
	output reg pin_pull_en, // Pull-up enable for the pin.
	output reg pin_in_en, // Input buffer enable for the pin.
	input wire cpu_clock_stopped // High in sleep with processor clock off.
);
	localparam S_IDLE = 5'b00001;
	localparam S_SYNC = 5'b00010;
	localparam S_SYNC_TAIL = 5'b00100;
	localparam S_RX = 5'b01000;
	localparam S_ERR = 5'b10000;

	function [8:0] link_mhz;
		input [1:0] sel;
		begin
			case (sel)
				`CLKSEL_16: link_mhz = `FREQ_16;
				`CLKSEL_8: link_mhz = `FREQ_8;
				default: link_mhz = `FREQ_4;
			endcase
		end
	endfunction

	function majority;
		input a;
		input b;
		input c;
		begin
			majority = (a & b) | (a & c) | (b & c);
		end
	endfunction

	reg [4:0] state;
	reg enable;
	reg parity_check_disable;
	reg [1:0] link_clock_select;
	reg pin_meta, line, line_d;
	reg sleep_meta, sleep_sync;
	reg [8:0] link_acc;
	reg link_tick;
	reg [19:0] samp_acc;
	reg sample_tick;
	reg [19:0] baud_count;
	reg [19:0] meas_cnt;
	reg [2:0] falls;
	reg [7:0] brk_cnt;
	reg [3:0] samp_idx;
	reg [3:0] bit_idx;
	reg s7, s8;
	reg [7:0] shift;
	reg [7:0] rx_data;
	reg rx_valid;
	reg expect_sync;
	reg [2:0] error_signature;
	reg ack_pending;
	reg tx_pending;
	reg [7:0] tx_hold;
	reg tx_start;
	reg [7:0] tx_byte;
	wire tx_line;
	wire tx_busy;
	wire [8:0] link_sum;
	wire [19:0] samp_sum;
	wire fall;
	wire vote;
	wire access;
	wire brk;
	wire launch;

	assign link_sum = link_acc + link_mhz(link_clock_select);
	assign samp_sum = samp_acc + `SYNC_SCALE;
	assign fall = line_d & ~line;
	assign vote = majority(s7, s8, line);
	assign access = psel & penable & pready;
	assign brk = sample_tick && !line && !tx_busy &&
		brk_cnt == `BREAK_SAMPLES - 8'h01;
	// Half duplex: only start sending while the receiver is quiet.
	assign launch = state == S_IDLE && enable && line && !tx_busy &&
		!tx_start && ((ack_pending && !sleep_sync) || tx_pending);

	one_wire_frame_tx u_tx (
		.pclk(pclk),
		.presetn(presetn),
		.sample_tick(sample_tick),
		.start(tx_start),
		.data(tx_byte),
		.line_o(tx_line),
		.busy(tx_busy)
	);

	// Pin and sleep level pass two flops before use.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_meta <= 1'b1;
			line <= 1'b1;
			line_d <= 1'b1;
			sleep_meta <= 1'b0;
			sleep_sync <= 1'b0;
		end else begin
			pin_meta <= pin_in;
			line <= pin_meta;
			line_d <= line;
			sleep_meta <= cpu_clock_stopped;
			sleep_sync <= sleep_meta;
		end
	end

	// Link clock as a fractional tick from the system clock.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			link_acc <= 9'h000;
			link_tick <= 1'b0;
		end else if (link_sum >= `PCLK_MHZ) begin
			link_acc <= link_sum - `PCLK_MHZ;
			link_tick <= 1'b1;
		end else begin
			link_acc <= link_sum;
			link_tick <= 1'b0;
		end
	end

	// Sample ticks: 128 per measured sync span, with carried remainder,
	// so the error never accumulates over a frame.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_acc <= 20'h00000;
			sample_tick <= 1'b0;
		end else if (state == S_IDLE && fall && !tx_busy) begin
			samp_acc <= 20'h00000;
			sample_tick <= 1'b0;
		end else if (link_tick && samp_sum >= baud_count) begin
			samp_acc <= samp_sum - baud_count;
			sample_tick <= 1'b1;
		end else begin
			samp_acc <= link_tick ? samp_sum : samp_acc;
			sample_tick <= 1'b0;
		end
	end

	// Break counter runs in every state, on the stored rate.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn)
			brk_cnt <= 8'h00;
		else if (line || tx_busy || brk)
			brk_cnt <= 8'h00;
		else if (sample_tick)
			brk_cnt <= brk_cnt + 8'h01;
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state <= S_IDLE;
			enable <= 1'b0;
			parity_check_disable <= 1'b0;
			link_clock_select <= `CLKSEL_RESET;
			baud_count <= `BAUD_DEFAULT;
			meas_cnt <= 20'h00000;
			falls <= 3'h0;
			samp_idx <= 4'h0;
			bit_idx <= 4'h0;
			s7 <= 1'b0;
			s8 <= 1'b0;
			shift <= 8'h00;
			rx_data <= 8'h00;
			rx_valid <= 1'b0;
			expect_sync <= 1'b1;
			error_signature <= `SIG_NONE;
			ack_pending <= 1'b0;
			tx_pending <= 1'b0;
			tx_hold <= 8'h00;
			tx_start <= 1'b0;
			tx_byte <= 8'h00;
		end else begin
			tx_start <= 1'b0;
			// Acknowledge is held while the processor clock is off.
			if (launch) begin
				tx_start <= 1'b1;
				if (ack_pending && !sleep_sync) begin
					tx_byte <= `ACK_CHAR;
					ack_pending <= 1'b0;
				end else begin
					tx_byte <= tx_hold;
					tx_pending <= 1'b0;
				end
			end
			// Software side after launch, so a request in that cycle is kept.
			if (access && pwrite) begin
				case (paddr)
				`OFS_CTRL: begin
					enable <= pwdata[`CTRL_ENABLE];
					parity_check_disable <=
						pwdata[`CTRL_PARITY_CHECK_DISABLE];
				end
				`OFS_ASYNC_IFACE_CONTROL_A:
					link_clock_select <= pwdata[1:0];
				`OFS_TXDATA: begin
					tx_hold <= pwdata[7:0];
					tx_pending <= 1'b1;
				end
				`OFS_CMD: begin
					if (pwdata[`CMD_STORE_GRANTED])
						ack_pending <= 1'b1;
					if (pwdata[`CMD_EXPECT_SYNC])
						expect_sync <= 1'b1;
				end
				default: ;
				endcase
			end
			if (access && !pwrite && paddr == `OFS_RXDATA)
				rx_valid <= 1'b0;
			if (access && !pwrite && paddr == `OFS_STATUS)
				error_signature <= `SIG_NONE;
			if (!enable) begin
				state <= S_IDLE;
				expect_sync <= 1'b1;
			end else if (brk) begin
				// Break recovers from any state.
				state <= S_IDLE;
				expect_sync <= 1'b1;
				link_clock_select <= `CLKSEL_RESET;
			end else begin
				case (state)
				S_IDLE: begin
					samp_idx <= 4'h0;
					bit_idx <= 4'h0;
					meas_cnt <= 20'h00000;
					falls <= 3'h0;
					if (fall && !tx_busy)
						state <= expect_sync ? S_SYNC : S_RX;
				end
				S_SYNC: begin
					// Eight bit times from start edge to fifth fall.
					if (link_tick)
						meas_cnt <= meas_cnt + 20'h00001;
					if (&meas_cnt) begin
						state <= S_ERR;
						error_signature <= `SIG_SYNC;
					end else if (fall) begin
						falls <= falls + 3'h1;
						if (falls == `SYNC_FALLS - 3'h1) begin
							if (meas_cnt < `BAUD_MIN) begin
								state <= S_ERR;
								error_signature <= `SIG_SYNC;
							end else begin
								baud_count <= meas_cnt;
								expect_sync <= 1'b0;
								state <= S_SYNC_TAIL;
							end
						end
					end
				end
				S_SYNC_TAIL: begin
					if (line)
						state <= S_IDLE;
				end
				S_RX: begin
					if (sample_tick) begin
						samp_idx <= samp_idx + 4'h1;
						if (samp_idx == `SAMPLE_A)
							s7 <= line;
						if (samp_idx == `SAMPLE_B)
							s8 <= line;
						if (samp_idx == `SAMPLE_LAST)
							bit_idx <= bit_idx + 4'h1;
						if (samp_idx == `SAMPLE_C) begin
							case (bit_idx)
							`BIT_START: if (vote) begin
								state <= S_ERR;
								error_signature <= `SIG_START;
							end
							`BIT_PARITY: if (!parity_check_disable &&
								vote != ^shift) begin
								state <= S_ERR;
								error_signature <= `SIG_PARITY;
							end
							`BIT_STOP1: if (!vote) begin
								state <= S_ERR;
								error_signature <= `SIG_STOP;
							end
							`BIT_STOP2: begin
								if (!vote) begin
									state <= S_ERR;
									error_signature <= `SIG_STOP;
								end else begin
									rx_data <= shift;
									rx_valid <= 1'b1;
									state <= S_IDLE;
								end
							end
							default: shift <= {vote, shift[7:1]};
							endcase
						end
					end
				end
				S_ERR: ; // Only a break or clearing enable leaves this state.
				default: state <= S_IDLE;
				endcase
			end
		end
	end

	// Pin control while active overrides the normal pin setup.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_out <= 1'b1;
			pin_out_en <= 1'b0;
			pin_pull_en <= 1'b0;
			pin_in_en <= 1'b0;
		end else begin
			pin_out <= tx_line;
			pin_out_en <= enable & tx_busy;
			pin_pull_en <= enable;
			pin_in_en <= enable;
		end
	end

	// APB: data and ready registered in the setup cycle, so every
	// access completes in one access cycle.
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else if (psel && !penable) begin
			pready <= 1'b1;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			case (paddr)
			`OFS_CTRL: begin
				prdata[`CTRL_ENABLE] <= enable;
				prdata[`CTRL_PARITY_CHECK_DISABLE] <= parity_check_disable;
			end
			`OFS_ASYNC_IFACE_CONTROL_A: prdata[1:0] <= link_clock_select;
			`OFS_STATUS: begin
				prdata[`ST_RX_VALID] <= rx_valid;
				prdata[`ST_TX_BUSY] <= tx_busy | tx_pending | tx_start;
				prdata[`ST_ERROR] <= state == S_ERR;
				prdata[`ST_EXPECT_SYNC] <= expect_sync;
				prdata[`ST_BUS_HELD] <= ack_pending & sleep_sync;
				prdata[`ST_SIG_HI:`ST_SIG_LO] <= error_signature;
			end
			`OFS_RXDATA: prdata[7:0] <= rx_data;
			`OFS_TXDATA: ;
			`OFS_CMD: ;
			`OFS_BAUD: prdata[19:0] <= baud_count;
			default: pslverr <= 1'b1;
			endcase
		end else begin
			pready <= 1'b0;
			pslverr <= 1'b0;
		end
	end
endmodule // one_wire_debug_port

// [one_wire_debug_port_monitor.sv]
`timescale 1ns/1ps
module one_wire_debug_port_monitor (
	input wire logic pclk, // Clock.
	input wire logic presetn, // Reset.
	input wire logic psel, // Select.
	input wire logic penable, // Enable.
	input wire logic pready, // Ready.
	input wire logic pslverr, // Error.
	input wire logic pin_in, // Pin level.
	input wire logic pin_out, // Drive level.
	input wire logic pin_out_en, // Drive enable.
	input wire logic pin_pull_en, // Pull enable.
	input wire logic pin_in_en // Input enable.
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [15:0] en_len;
	always @(posedge pclk or negedge presetn)
		if (!presetn)
			en_len <= 16'h0000;
		else if (pin_out_en)
			en_len <= en_len + 16'h0001;
		else
			en_len <= 16'h0000;
	ready_follows_a: assert property (psel && !penable |-> ##[1:2] pready)
		else $error("Ready missing after setup");
	ready_pulse_a: assert property (pready |=> !pready)
		else $error("Ready held too long");
	error_ready_a: assert property (pslverr |-> pready && psel && penable)
		else $error("Error outside access");
	idle_high_a: assert property (!pin_out_en |-> pin_out)
		else $error("Idle level not high");
	start_low_a: assert property (
		$rose(pin_out_en) |-> ##[0:2] !pin_out [*8])
		else $error("Start bit not low");
	// Shortest legal frame is twelve bits at the fastest sample rate.
	frame_min_a: assert property (
		$fell(pin_out_en) |-> en_len >= 16'h08FC)
		else $error("Frame too short");
	enables_pair_a: assert property (pin_pull_en == pin_in_en)
		else $error("Pull and input enables differ");
	drive_on_a: assert property (pin_out_en |-> pin_in_en)
		else $error("Drive while port inactive");
	line_free_a: assert property (
		$rose(pin_out_en) |-> $past(pin_in) && $past(pin_in, 2))
		else $error("Drive while line busy");
endmodule // one_wire_debug_port_monitor

bind one_wire_debug_port one_wire_debug_port_monitor u_monitor (
	.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
	.pready(pready), .pslverr(pslverr), .pin_in(pin_in), .pin_out(pin_out),
	.pin_out_en(pin_out_en), .pin_pull_en(pin_pull_en),
	.pin_in_en(pin_in_en));

// [link_master.sv]
`timescale 1ns/1ps
module link_master #(
	parameter int BIT = 250
) (
	input wire logic pclk, // Clock.
	input wire logic line, // Pin level.
	output logic drv, // Master drives.
	output logic lvl, // Driven level.
	output logic [8:0] rx_byte, // Frame ok and byte.
	output logic rx_stb // Frame received.
);
	logic [11:0] f;
	logic talked;
	initial begin
		drv = 1'b0;
		lvl = 1'b1;
		rx_stb = 1'b0;
		rx_byte = 9'h000;
		talked = 1'b0;
	end
	task automatic send(input logic [7:0] d, input logic bp, input logic bs);
		f = {1'b1, ~bs, ^d ^ bp, d, 1'b0};
		talked = 1'b1;
		@(posedge pclk);
		for (int k = 0; k < 12; k++) begin
			drv <= 1'b1;
			lvl <= f[k];
			repeat (BIT) @(posedge pclk);
		end
		drv <= 1'b0;
	endtask
	task automatic brk();
		@(posedge pclk);
		drv <= 1'b1;
		lvl <= 1'b0;
		repeat (13 * BIT) @(posedge pclk);
		lvl <= 1'b1;
		repeat (2 * BIT) @(posedge pclk);
		drv <= 1'b0;
	endtask
	// Listens only after first talking, since the line floats before that.
	always begin
		@(negedge line iff (talked && !drv));
		repeat (BIT / 2) @(posedge pclk);
		for (int k = 0; k < 12; k++) begin
			f[k] = line;
			repeat (BIT) @(posedge pclk);
		end
		rx_byte <= {f[11:10] == 2'h3 && !f[0] && !(^f[9:1]), f[8:1]};
		rx_stb <= 1'b1;
		@(posedge pclk);
		rx_stb <= 1'b0;
	end
endmodule // link_master

// [tb_top.sv]
`timescale 1ns/1ps
`include "one_wire_debug_port_defines.vh"
module tb_top;
	typedef struct {logic e; logic [31:0] v; logic [31:0] m; string s;} note_t;
	logic pclk, presetn, psel, penable, pwrite, cpu_clock_stopped;
	logic pready, pslverr, pin_out, pin_out_en, pin_pull_en, pin_in_en;
	logic m_drv, m_lvl, rx_stb;
	logic [7:0] paddr, b;
	logic [8:0] rx_byte;
	logic [31:0] pwdata, prdata, seed;
	wire line;
	note_t q[$];
	note_t n;
	int failures, tests_run;
	// A floating pin with pull-up off toggles rather than keeping a level.
	assign line = pin_out_en ? pin_out : m_drv ? m_lvl : pin_pull_en | pclk;
	one_wire_debug_port dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(line),
		.pin_out(pin_out), .pin_out_en(pin_out_en), .pin_pull_en(pin_pull_en),
		.pin_in_en(pin_in_en), .cpu_clock_stopped(cpu_clock_stopped));
	link_master m (.pclk(pclk), .line(line), .drv(m_drv), .lvl(m_lvl),
		.rx_byte(rx_byte), .rx_stb(rx_stb));
	initial begin
		pclk = 1'b0;
		forever #2.5 pclk = ~pclk;
	end
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input logic e, input logic [31:0] v);
		n = q.pop_front();
		tests_run++;
		if (e !== n.e || (v & n.m) !== n.v) begin
			failures++;
			$display("Error %s expected %h seen %h", n.s, n.v, v & n.m);
		end
	endtask
	always @(posedge pclk) begin
		if (psel && penable && pready === 1'b1 && !pwrite)
			check(pslverr, prdata);
		if (rx_stb === 1'b1)
			check(1'b0, {23'h0, rx_byte});
	end
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] v,
		input logic [31:0] mk, input string s, input logic e = 1'b0);
		q.push_back('{e, v, mk, s});
		apb(1'b0, a, 32'h0);
	endtask
	task automatic tx_wait(input logic [8:0] v);
		int t;
		q.push_back('{1'b0, {23'h0, v}, 32'h1FF, "tx frame"});
		t = 0;
		do begin
			@(posedge pclk);
			t++;
		end while (rx_stb !== 1'b1 && t < 4000);
		if (rx_stb !== 1'b1) begin
			failures++;
			$display("Error tx frame expected %h seen none", v);
		end
		@(posedge pclk);
	endtask
	task automatic sync();
		apb(1'b1, 8'h04, 32'h1);
		m.send(8'h55, 1'b0, 1'b0);
	endtask
	task automatic end_of_test();
		if (failures == 0 && tests_run > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial begin
		repeat (80000) @(posedge pclk);
		failures++;
		end_of_test();
	end
	initial begin
		seed = 32'h2C;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cpu_clock_stopped = 1'b0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		rd(8'h00, 32'h0, 32'h3, "ctrl");
		rd(8'h04, 32'h3, 32'h3, "clock select");
		rd(8'h1C, 32'h0, 32'h0, "unmapped", 1'b1);
		apb(1'b1, 8'h00, 32'h1);
		apb(1'b1, 8'h18, 32'h0);
		rd(8'h18, 32'h118, '1, "bit count");
		sync();
		rd(8'h18, 32'h80, 32'hFFFC0, "measured count");
		rd(8'h08, 32'h0, 32'h8, "expect sync");
		for (int i = 0; i < 3; i++) begin
			b = rnd();
			m.send(b, 1'b0, 1'b0);
			rd(8'h08, 32'h1, 32'h5, "rx status");
			rd(8'h0C, {24'h0, b}, 32'hFF, "rx data");
		end
		apb(1'b1, 8'h00, 32'h3);
		m.send(b, 1'b1, 1'b0);
		rd(8'h08, 32'h1, 32'h705, "status");
		rd(8'h0C, {24'h0, b}, 32'hFF, "rx data");
		apb(1'b1, 8'h00, 32'h1);
		for (int k = 2; k < 4; k++) begin
			m.send(b, k == 2, k == 3);
			m.send(~b, 1'b0, 1'b0);
			rd(8'h08, k << 8 | 4, 32'h705, "error status");
			rd(8'h08, 32'h4, 32'h704, "signature clear");
			m.brk();
			rd(8'h08, 32'h8, 32'hC, "after break");
			rd(8'h04, 32'h3, 32'h3, "clock select");
			sync();
		end
		apb(1'b1, 8'h10, 32'hA5);
		tx_wait(9'h1A5);
		apb(1'b1, 8'h14, 32'h1);
		tx_wait({1'b1, `ACK_CHAR});
		cpu_clock_stopped <= 1'b1;
		apb(1'b1, 8'h14, 32'h1);
		repeat (50) @(posedge pclk);
		rd(8'h08, 32'h10, 32'h10, "bus held");
		cpu_clock_stopped <= 1'b0;
		tx_wait({1'b1, `ACK_CHAR});
		apb(1'b1, 8'h14, 32'h2);
		rd(8'h08, 32'h8, 32'h8, "sync request");
		// Too fast for the 8 MHz link clock, so the sync is refused.
		apb(1'b1, 8'h04, 32'h2);
		m.send(8'h55, 1'b0, 1'b0);
		rd(8'h08, 32'h40C, 32'h70C, "sync error");
		if (q.size() != 0)
			failures++;
		end_of_test();
	end
endmodule // tb_top
